// >>> hw/ser_modem_pkg.sv
// Shared types and constants for the serial modem-control block.
// Assumes one core clock domain plus one receive clock per channel.
package ser_modem_pkg;

  // Two serial channels, index 0 is A and index 1 is B.
  localparam int unsigned NUM_CHAN        = 2;
  // Bit of the pin mux register that hands the A pin to the serial logic.
  localparam int unsigned PIN_MUX_RTS_BIT = 3;
  // Receive clock cycles per data bit for each rate choice.
  localparam logic [6:0]  MULT_X1         = 7'h01;
  localparam logic [6:0]  MULT_X16        = 7'h10;
  localparam logic [6:0]  MULT_X32        = 7'h20;
  localparam logic [6:0]  MULT_X64        = 7'h40;

  // Receive modes, Gray coded in the order they are usually stepped.
  typedef enum logic [1:0] {
    MODE_ASYNC    = 2'h0,
    MODE_EXT_SYNC = 2'h1,
    MODE_INT_SYNC = 2'h3,
    MODE_SDLC     = 2'h2
  } rx_mode_t;

  // Receive clock to data rate ratio in asynchronous mode.
  typedef enum logic [1:0] {
    RATE_X1  = 2'h0,
    RATE_X16 = 2'h1,
    RATE_X32 = 2'h3,
    RATE_X64 = 2'h2
  } clk_rate_t;

  // The part of the configuration that the receive clock side needs.
  typedef struct packed {
    rx_mode_t  mode;
    clk_rate_t rate;
    logic      xtal_osc;
  } link_cfg_t;

  // Per-channel control bits written by software.
  typedef struct packed {
    link_cfg_t link;
    logic      auto_enable;
    logic      rts_bit;
    logic      dtr_bit;
    logic      dtr_dma;
    logic      req_mode;
    logic      ie_cts;
    logic      ie_dcd;
  } chan_cfg_t;

  // Per-channel inputs from the transmitter, receiver and processor.
  typedef struct packed {
    logic tx_empty;
    logic tx_dma_req;
    logic rx_dma_req;
    logic wait_cond;
  } chan_in_t;

  // Per-channel status seen by software.
  typedef struct packed {
    logic cts_active;
    logic dcd_active;
    logic sync_hunt;
    logic tx_enable;
    logic rx_enable;
    logic ext_event;
  } chan_stat_t;

  // Cycles of receive clock per bit for a rate choice.
  function automatic logic [6:0] rate_count(input clk_rate_t r);
    logic [6:0] c;
    c = MULT_X1;
    unique case (r)
      RATE_X1:  c = MULT_X1;
      RATE_X16: c = MULT_X16;
      RATE_X32: c = MULT_X32;
      RATE_X64: c = MULT_X64;
    endcase
    return c;
  endfunction

  // True in the modes where the sync pin is an output.
  function automatic logic sync_is_output(input link_cfg_t c);
    return !c.xtal_osc &&
           (c.mode == MODE_INT_SYNC || c.mode == MODE_SDLC);
  endfunction

endpackage

// >>> hw/ser_sync_link.sv
// Receive-clock side of one channel: sync pin, bit timing, assembly start.
// Assumes the receiver's hunt and flag strobes come on the same clock.
`timescale 1ns/1ps
module ser_sync_link import ser_modem_pkg::*; (
  input  wire logic      rx_clock,      // Receive clock of the channel.
  input  wire logic      rst_n,         // Core reset, released locally.
  input  wire link_cfg_t cfg,           // Quasi-static core setting.
  input  wire logic      sync_pin_n_in, // Sync pin level.
  input  wire logic      rx_data,       // Serial data on this clock.
  input  wire logic      hunt_match,    // Sync character recognised.
  input  wire logic      flag_seen,     // Opening or closing flag.
  output logic           sync_pin_n_out,
  output logic           sync_pin_oe,
  output logic           asm_start,     // Assembly starts, one cycle.
  output logic           asm_first_bit, // First bit of the character.
  output logic           bit_tick,      // One bit time has passed.
  output logic           recog_toggle   // Flips per recognition.
);

  // All state of the receive side.
  typedef struct packed {
    link_cfg_t  cfg_m;
    link_cfg_t  cfg_s;
    logic       sync_m;
    logic       sync_s;
    logic       sync_d;
    logic [2:0] hist;
    logic [6:0] cnt;
    logic       tick;
    logic       start;
    logic       first;
    logic       out_n;
    logic       oe;
    logic       tog;
  } link_t;

  // Pins rest high, so the sync chain resets to the idle level.
  localparam link_t LINK_RST = '{sync_m: 1'h1, sync_s: 1'h1,
                                 sync_d: 1'h1, out_n: 1'h1,
                                 default: '0};

  logic [1:0] lrst_q;  // Local reset release chain.
  logic       lrst_n;  // Reset for this domain.
  link_t      q;       // Registered state.
  link_t      d;       // Next state.

  // Reset asserts at once and releases on this clock only.
  always_ff @(posedge rx_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'h1};
    end
  end
  assign lrst_n = lrst_q[1];

  // Next-state logic for the whole receive side.
  always_comb begin
    d        = q;
    d.cfg_m  = cfg;
    d.cfg_s  = q.cfg_m;
    d.sync_m = sync_pin_n_in;
    d.sync_s = q.sync_m;
    d.sync_d = q.sync_s;
    d.hist   = {q.hist[1:0], rx_data};
    // Bit timer, one tick per bit at the chosen ratio in async mode, every clock otherwise.
    if (q.cfg_s.mode == MODE_ASYNC &&
        q.cnt != 7'(rate_count(q.cfg_s.rate) - 7'h01)) begin
      d.cnt  = 7'(q.cnt + 7'h01);
      d.tick = 1'h0;
    end else begin
      d.cnt  = 7'h00;
      d.tick = 1'h1;
    end
    // The pin is seen two edges late, so the edge before its fall is
    // three edges back in the data history.
    d.start = q.cfg_s.mode == MODE_EXT_SYNC && !q.cfg_s.xtal_osc &&
              q.sync_d && !q.sync_s;
    d.first = d.start ? q.hist[2] : q.first;
    // The output is never held: it follows each recognition.
    d.oe    = sync_is_output(q.cfg_s);
    d.out_n = 1'h1;
    if (d.oe) begin
      if (q.cfg_s.mode == MODE_INT_SYNC) begin
        d.out_n = !hunt_match;
      end else begin
        d.out_n = !flag_seen;
      end
    end
    // Each recognition is passed to the core as a toggle.
    if (d.oe && !d.out_n) begin
      d.tog = !q.tog;
    end
  end

  // State register of the receive side.
  always_ff @(posedge rx_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      q <= LINK_RST;
    end else begin
      q <= d;
    end
  end

  assign sync_pin_n_out = q.out_n;
  assign sync_pin_oe    = q.oe;
  assign asm_start      = q.start;
  assign asm_first_bit  = q.first;
  assign bit_tick       = q.tick;
  assign recog_toggle   = q.tog;

  // A recognition in monosync or bisync drives the pin low next cycle.
  property p_int_sync_pulse;
    @(posedge rx_clock) disable iff (!lrst_n)
      (q.cfg_s.mode == MODE_INT_SYNC && !q.cfg_s.xtal_osc && hunt_match)
      |=> (sync_pin_oe && !sync_pin_n_out) ##1
          (sync_pin_n_out == !$past(hunt_match));
  endproperty
  a_int_sync_pulse: assert property (p_int_sync_pulse)
    else $error("sync output does not follow recognition");

  // Assembly starts with the bit taken on the edge before the fall.
  property p_ext_sync_start;
    @(posedge rx_clock) disable iff (!lrst_n)
      asm_start |-> asm_first_bit == $past(rx_data, 4);
  endproperty
  a_ext_sync_start: assert property (p_ext_sync_start)
    else $error("assembly start takes the wrong first bit");

endmodule

// >>> hw/ser_modem_ctrl.sv
// Modem-control, sync and wait/request pin logic for two channels.
// Assumes active-low pins outside, software bits and strobes on clock.
`timescale 1ns/1ps
module ser_modem_ctrl import ser_modem_pkg::*; (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       chan_a_rx_clock,
  input  wire logic       chan_b_rx_clock,
  input  wire chan_cfg_t  cfg_a,
  input  wire chan_cfg_t  cfg_b,
  input  wire chan_in_t   in_a,
  input  wire chan_in_t   in_b,
  input  wire logic [7:0] pin_mux_reg,
  input  wire logic       mem_request,
  input  wire logic       mem_write,
  input  wire logic       chan_a_clear_to_send_n,
  input  wire logic       chan_b_clear_to_send_n,
  input  wire logic       chan_a_carrier_detect_n,
  input  wire logic       chan_b_carrier_detect_n,
  input  wire logic       chan_a_sync_pin_n_in,
  input  wire logic       chan_b_sync_pin_n_in,
  input  wire logic       chan_a_rx_data,
  input  wire logic       chan_b_rx_data,
  input  wire logic       chan_a_hunt_match,
  input  wire logic       chan_b_hunt_match,
  input  wire logic       chan_a_flag_seen,
  input  wire logic       chan_b_flag_seen,
  output chan_stat_t      stat_a,
  output chan_stat_t      stat_b,
  output logic            chan_a_request_to_send_n,
  output logic            chan_b_request_to_send_n,
  output logic            chan_a_terminal_ready_dma_req_n,
  output logic            chan_b_terminal_ready_dma_req_n,
  output logic            chan_a_wait_or_request_n_out,
  output logic            chan_a_wait_or_request_oe,
  output logic            chan_b_wait_or_request_n_out,
  output logic            chan_b_wait_or_request_oe,
  output logic            chan_a_sync_pin_n_out,
  output logic            chan_a_sync_pin_oe,
  output logic            chan_b_sync_pin_n_out,
  output logic            chan_b_sync_pin_oe,
  output logic            chan_a_asm_start,
  output logic            chan_b_asm_start,
  output logic            chan_a_asm_first_bit,
  output logic            chan_b_asm_first_bit,
  output logic            chan_a_bit_tick,
  output logic            chan_b_bit_tick
);

  // All state of the core side, one entry per channel in each vector.
  typedef struct packed {
    logic [1:0]       cts_m;    // Clear-to-send chain, active high.
    logic [1:0]       cts_s;
    logic [1:0]       dcd_m;    // Carrier-detect chain, active high.
    logic [1:0]       dcd_s;
    logic [1:0]       syn_m;    // Sync pin chain, active high.
    logic [1:0]       syn_s;
    logic [1:0]       tog_m;    // Recognition toggles from the link.
    logic [1:0]       tog_s;
    logic [1:0]       tog_d;
    chan_stat_t [1:0] stat;
    logic [1:0]       srts_n;   // Serial request-to-send state.
    logic [1:0]       rts_pin;  // Request-to-send pins.
    logic [1:0]       dtr_n;
    logic [1:0]       wr_out;
    logic [1:0]       wr_oe;
  } core_t;

  // Outputs come out of reset idle high; wait lines stay released.
  localparam core_t CORE_RST = '{srts_n: 2'h3, rts_pin: 2'h3,
                                 dtr_n: 2'h3, default: '0};

  logic [1:0]       rst_q;   // Reset release chain.
  logic             rst_n;   // Released reset for the whole block.
  core_t            q;       // Registered state.
  core_t            d;       // Next state.
  chan_cfg_t [1:0]  cfg_v;   // Channel settings by index.
  chan_in_t  [1:0]  in_v;    // Channel inputs by index.
  logic      [1:0]  cts_p;   // Raw pins by index.
  logic      [1:0]  dcd_p;
  logic      [1:0]  syn_p;
  logic      [1:0]  tog_l;   // Toggles from the two link sides.
  logic             cts_a;   // Settled clear-to-send of one channel.
  logic             dcd_a;   // Settled carrier detect of one channel.
  logic             syn_a;   // Settled sync pin of one channel.
  logic             e_cts;   // Clear-to-send changed this cycle.
  logic             e_dcd;   // Carrier detect changed this cycle.
  logic             recog;   // The link reported a recognition.
  logic             async_auto; // Async mode with auto enables on.
  rx_mode_t         md;      // Receive mode of one channel.

  assign cfg_v = {cfg_b, cfg_a};
  assign in_v  = {in_b, in_a};
  assign cts_p = {chan_b_clear_to_send_n, chan_a_clear_to_send_n};
  assign dcd_p = {chan_b_carrier_detect_n, chan_a_carrier_detect_n};
  assign syn_p = {chan_b_sync_pin_n_in, chan_a_sync_pin_n_in};

  // Reset asserts at once and is released on the core clock.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'h1};
    end
  end
  assign rst_n = rst_q[1];

  // Receive-clock side of channel A.
  ser_sync_link link_a (
    .rx_clock       (chan_a_rx_clock),
    .rst_n          (rst_n),
    .cfg            (cfg_a.link),
    .sync_pin_n_in  (chan_a_sync_pin_n_in),
    .rx_data        (chan_a_rx_data),
    .hunt_match     (chan_a_hunt_match),
    .flag_seen      (chan_a_flag_seen),
    .sync_pin_n_out (chan_a_sync_pin_n_out),
    .sync_pin_oe    (chan_a_sync_pin_oe),
    .asm_start      (chan_a_asm_start),
    .asm_first_bit  (chan_a_asm_first_bit),
    .bit_tick       (chan_a_bit_tick),
    .recog_toggle   (tog_l[0])
  );

  // Receive-clock side of channel B, the same logic.
  ser_sync_link link_b (
    .rx_clock       (chan_b_rx_clock),
    .rst_n          (rst_n),
    .cfg            (cfg_b.link),
    .sync_pin_n_in  (chan_b_sync_pin_n_in),
    .rx_data        (chan_b_rx_data),
    .hunt_match     (chan_b_hunt_match),
    .flag_seen      (chan_b_flag_seen),
    .sync_pin_n_out (chan_b_sync_pin_n_out),
    .sync_pin_oe    (chan_b_sync_pin_oe),
    .asm_start      (chan_b_asm_start),
    .asm_first_bit  (chan_b_asm_first_bit),
    .bit_tick       (chan_b_bit_tick),
    .recog_toggle   (tog_l[1])
  );

  // Next-state logic; one loop body serves both channels.
  always_comb begin
    d = q;
    // Pins are inverted ahead of the chains so the chains hold
    // active-high levels; no logic reads a first stage.
    d.cts_m = ~cts_p;
    d.cts_s = q.cts_m;
    d.dcd_m = ~dcd_p;
    d.dcd_s = q.dcd_m;
    d.syn_m = ~syn_p;
    d.syn_s = q.syn_m;
    d.tog_m = tog_l;
    d.tog_s = q.tog_m;
    d.tog_d = q.tog_s;
    for (int i = 0; i < NUM_CHAN; i++) begin
      md    = cfg_v[i].link.mode;
      cts_a = q.cts_s[i];
      dcd_a = q.dcd_s[i];
      syn_a = q.syn_s[i];
      recog = q.tog_s[i] ^ q.tog_d[i];
      // Edges compare the settled level against the stored one, so
      // each transition is reported once.
      e_cts = cts_a != q.stat[i].cts_active;
      e_dcd = dcd_a != q.stat[i].dcd_active;
      d.stat[i].cts_active = cts_a;
      d.stat[i].dcd_active = dcd_a;
      // Either edge of either input may interrupt.
      d.stat[i].ext_event  = (e_cts && cfg_v[i].ie_cts) ||
                             (e_dcd && cfg_v[i].ie_dcd);
      // Without auto enable the inputs are plain status.
      d.stat[i].tx_enable  = !cfg_v[i].auto_enable ||
                             q.stat[i].cts_active;
      d.stat[i].rx_enable  = !cfg_v[i].auto_enable ||
                             q.stat[i].dcd_active;
      // Sync pin as input feeds the hunt bit here; in external sync mode the link side also starts assembly on its fall.
      if (sync_is_output(cfg_v[i].link)) begin
        // Leaving hunt on a recognition; it is not re-entered here.
        if (recog) begin
          d.stat[i].sync_hunt = 1'h0;
        end
      end else begin
        d.stat[i].sync_hunt = syn_a;
      end
      // Request-to-send: set drives low; in async with auto enable a
      // clear waits for an empty transmitter.
      async_auto = md == MODE_ASYNC && cfg_v[i].auto_enable;
      if (cfg_v[i].rts_bit) begin
        d.srts_n[i] = 1'h0;
      end else if (async_auto) begin
        d.srts_n[i] = q.srts_n[i] | in_v[i].tx_empty;
      end else begin
        d.srts_n[i] = 1'h1;
      end
      d.rts_pin[i] = d.srts_n[i];
      // Terminal ready shows its bit or the transmit DMA request.
      d.dtr_n[i] = cfg_v[i].dtr_dma ? !in_v[i].tx_dma_req
                                    : !cfg_v[i].dtr_bit;
      // Request function drives both levels; wait only pulls low
      // while the processor must be held.
      if (cfg_v[i].req_mode) begin
        d.wr_out[i] = !in_v[i].rx_dma_req;
        d.wr_oe[i]  = 1'h1;
      end else begin
        d.wr_out[i] = 1'h0;
        d.wr_oe[i]  = in_v[i].wait_cond;
      end
    end
    // Until software flips the mux bit, pin A carries the memory
    // write strobe; the serial state runs on underneath.
    if (!pin_mux_reg[PIN_MUX_RTS_BIT]) begin
      d.rts_pin[0] = !(mem_request && mem_write);
    end
  end

  // State register of the core side.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign stat_a                          = q.stat[0];
  assign stat_b                          = q.stat[1];
  assign chan_a_request_to_send_n        = q.rts_pin[0];
  assign chan_b_request_to_send_n        = q.rts_pin[1];
  assign chan_a_terminal_ready_dma_req_n = q.dtr_n[0];
  assign chan_b_terminal_ready_dma_req_n = q.dtr_n[1];
  assign chan_a_wait_or_request_n_out    = q.wr_out[0];
  assign chan_a_wait_or_request_oe       = q.wr_oe[0];
  assign chan_b_wait_or_request_n_out    = q.wr_out[1];
  assign chan_b_wait_or_request_oe       = q.wr_oe[1];

  // A set request bit drives the channel B pin low next cycle.
  property p_rts_set;
    @(posedge clock) disable iff (!rst_n)
      cfg_b.rts_bit |=> !chan_b_request_to_send_n;
  endproperty
  a_rts_set: assert property (p_rts_set)
    else $error("request pin not low after bit set");

  // In async auto mode a low pin holds while the transmitter is busy.
  property p_rts_hold;
    @(posedge clock) disable iff (!rst_n)
      (!cfg_b.rts_bit && cfg_b.auto_enable && !in_b.tx_empty &&
       cfg_b.link.mode == MODE_ASYNC && !chan_b_request_to_send_n)
      |=> !chan_b_request_to_send_n;
  endproperty
  a_rts_hold: assert property (p_rts_hold)
    else $error("request pin rose before transmitter empty");

  // Outside async auto mode the pin follows the bit directly.
  property p_rts_follow;
    @(posedge clock) disable iff (!rst_n)
      (!cfg_b.rts_bit &&
       (!cfg_b.auto_enable || cfg_b.link.mode != MODE_ASYNC))
      |=> chan_b_request_to_send_n;
  endproperty
  a_rts_follow: assert property (p_rts_follow)
    else $error("request pin does not follow its bit");

  // Before the mux bit is set pin A is the inverted write strobe.
  property p_mwr_pin;
    @(posedge clock) disable iff (!rst_n)
      !pin_mux_reg[PIN_MUX_RTS_BIT] |=>
        chan_a_request_to_send_n == !$past(mem_request && mem_write);
  endproperty
  a_mwr_pin: assert property (p_mwr_pin)
    else $error("pin A does not carry the write strobe");

  // The terminal-ready pin shows the transmit DMA request when asked.
  property p_dtr_dma;
    @(posedge clock) disable iff (!rst_n)
      cfg_a.dtr_dma |=>
        chan_a_terminal_ready_dma_req_n == !$past(in_a.tx_dma_req);
  endproperty
  a_dtr_dma: assert property (p_dtr_dma)
    else $error("terminal-ready pin ignores DMA request");

  // In wait function the line never drives high.
  property p_wait_od;
    @(posedge clock) disable iff (!rst_n)
      !cfg_a.req_mode |=> !chan_a_wait_or_request_n_out;
  endproperty
  a_wait_od: assert property (p_wait_od)
    else $error("wait line driven high");

  // In request function the line is driven with the receive request.
  property p_req_drive;
    @(posedge clock) disable iff (!rst_n)
      cfg_a.req_mode |=> chan_a_wait_or_request_oe &&
        chan_a_wait_or_request_n_out == !$past(in_a.rx_dma_req);
  endproperty
  a_req_drive: assert property (p_req_drive)
    else $error("request line not driven from DMA request");

  // Auto enable passes the settled clear-to-send level to the sender.
  property p_tx_gate;
    @(posedge clock) disable iff (!rst_n)
      cfg_a.auto_enable |=> stat_a.tx_enable == $past(stat_a.cts_active);
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("transmitter gate does not follow clear-to-send");

  // A clear-to-send change with its enable set raises an event.
  property p_cts_event;
    @(posedge clock) disable iff (!rst_n)
      ($changed(stat_a.cts_active) && $past(cfg_a.ie_cts))
      |-> stat_a.ext_event;
  endproperty
  a_cts_event: assert property (p_cts_event)
    else $error("clear-to-send edge raised no event");

endmodule

// >>> verification/modem_model.sv
// Line-side model that drives the channel's sync line in external sync mode.
// Assumes the bench pulses char_done for one receive clock per character.
`timescale 1ns/1ps
module modem_model (
  input  wire logic rx_clock,  // Receive clock of the channel.
  input  wire logic char_done, // Last sync bit has just arrived.
  input  wire logic pin_oe,    // Device drives the pin.
  input  wire logic pin_out,   // Device level on the pin.
  output logic      line_n     // Resolved level of the pin.
);
  logic [1:0] dly_q = 2'h0; // Two-clock delay before the drop.
  logic       drv_n = 1'b1; // Own drive; the pull-up holds it high.
  // Pull the line low two clocks after the character, for one clock.
  always @(posedge rx_clock) begin
    dly_q <= {dly_q[0], char_done};
    drv_n <= #1 !dly_q[1];
  end
  // The device wins while it drives; else the pull-up or our drive.
  assign line_n = pin_oe ? pin_out : drv_n;
endmodule

// >>> verification/tb.sv
// Self-checking bench for the modem-control and sync pin block.
// Assumes one shared 30 ns receive clock for both channels.
`timescale 1ns/1ps
module tb;
  import ser_modem_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, rxc = 1'b0, dat = 1'b0;
  logic hunt = 1'b0, flag = 1'b0, done = 1'b0, mreq = 1'b0, mwr = 1'b0;
  logic cts_a = 1'b1, dcd_a = 1'b1, cts_b = 1'b1, dcd_b = 1'b1;
  logic [7:0] mux = 8'h00;
  chan_cfg_t ca = '0, cb = '0;
  chan_in_t ia = '0, ib = '0;
  chan_stat_t sa, sb;
  logic rts_a, rts_b, dtr_a, dtr_b, wa, wao, sya, syao, syb, sybo;
  logic asa, line_a, line_b, bta, afa, pre = 1'b0, exp_fb = 1'b0;
  int failures = 0, n_tests = 0, ev = 0, nt = 0;
  rx_mode_t md [2] = '{MODE_INT_SYNC, MODE_SDLC};
  always #2 clock = !clock;
  // Receive clock offset so its rising edges never meet the bench's input changes.
  initial begin
    #3;
    forever #15 rxc = !rxc;
  end
  // Sync pin B has a pull-up when the device releases it.
  assign line_b = sybo ? syb : 1'b1;
  modem_model partner (.rx_clock(rxc), .char_done(done), .pin_oe(syao),
    .pin_out(sya), .line_n(line_a));
  ser_modem_ctrl DUT (.clock(clock), .nrst(nrst), .chan_a_rx_clock(rxc),
    .chan_b_rx_clock(rxc), .cfg_a(ca), .cfg_b(cb), .in_a(ia), .in_b(ib),
    .pin_mux_reg(mux), .mem_request(mreq), .mem_write(mwr),
    .chan_a_clear_to_send_n(cts_a), .chan_b_clear_to_send_n(cts_b),
    .chan_a_carrier_detect_n(dcd_a), .chan_b_carrier_detect_n(dcd_b),
    .chan_a_sync_pin_n_in(line_a), .chan_b_sync_pin_n_in(line_b),
    .chan_a_rx_data(dat), .chan_b_rx_data(dat),
    .chan_a_hunt_match(hunt), .chan_b_hunt_match(hunt),
    .chan_a_flag_seen(flag), .chan_b_flag_seen(flag),
    .stat_a(sa), .stat_b(sb), .chan_a_request_to_send_n(rts_a),
    .chan_b_request_to_send_n(rts_b),
    .chan_a_terminal_ready_dma_req_n(dtr_a),
    .chan_b_terminal_ready_dma_req_n(dtr_b),
    .chan_a_wait_or_request_n_out(wa), .chan_a_wait_or_request_oe(wao),
    .chan_b_wait_or_request_n_out(), .chan_b_wait_or_request_oe(),
    .chan_a_sync_pin_n_out(sya), .chan_a_sync_pin_oe(syao),
    .chan_b_sync_pin_n_out(syb), .chan_b_sync_pin_oe(sybo),
    .chan_a_asm_start(asa), .chan_b_asm_start(),
    .chan_a_asm_first_bit(afa), .chan_b_asm_first_bit(),
    .chan_a_bit_tick(bta), .chan_b_bit_tick());
  // Count change events of channel A; each is a one-cycle pulse.
  always @(posedge clock) begin
    if (sa.ext_event === 1'b1) ev++;
  end
  // Serial data alternates on every rising receive edge.
  always @(posedge rxc) dat <= !dat;
  // Keep the data bit taken on the edge before the sync pin fell.
  always @(posedge rxc) begin
    if (line_a === 1'b0) exp_fb <= pre;
    pre <= dat;
  end
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bounded wait on the receive clock; strobes last one clock only.
  task automatic wait_rx(input string nm, input bit b);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge rxc);
      #1;
      {hunt, flag, done} = 3'h0;
      if (b ? (syb === 1'b0 && sybo === 1'b1) : asa === 1'b1) break;
    end
    chk(nm, 1'b1, i < 12);
    if (i == 12) wrap_up();
  endtask
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(4);
    chk("rts b reset", 1'b1, rts_b);
    chk("wait oe reset", 1'b0, wao);
    mreq = 1'b1;
    mwr = 1'b1;
    tick(2);
    chk("write strobe", 1'b0, rts_a);
    mreq = 1'b0;
    mux = 8'h08;
    ca.rts_bit = 1'b1;
    cb.rts_bit = 1'b1;
    cb.auto_enable = 1'b1;
    tick(2);
    chk("rts a", 1'b0, rts_a);
    chk("rts b", 1'b0, rts_b);
    cb.rts_bit = 1'b0;
    tick(4);
    chk("rts held", 1'b0, rts_b);
    ib.tx_empty = 1'b1;
    tick(2);
    chk("rts empty", 1'b1, rts_b);
    chk("b tx gate", 1'b0, sb.tx_enable);
    cb.auto_enable = 1'b0;
    ib.tx_empty = 1'b0;
    cb.rts_bit = 1'b1;
    tick(2);
    chk("rts set", 1'b0, rts_b);
    cb.rts_bit = 1'b0;
    tick(2);
    chk("rts direct", 1'b1, rts_b);
    cb.dtr_bit = 1'b1;
    ca.dtr_dma = 1'b1;
    ia.tx_dma_req = 1'b1;
    ia.wait_cond = 1'b1;
    tick(2);
    chk("dtr bit", 1'b0, dtr_b);
    chk("dtr dma", 1'b0, dtr_a);
    chk("wait low", 1'b0, wao === 1'b1 ? wa : 1'b1);
    ia = '0;
    ca.req_mode = 1'b1;
    tick(2);
    chk("req high", 1'b1, wao === 1'b1 && wa === 1'b1);
    ia.rx_dma_req = 1'b1;
    tick(2);
    chk("req low", 1'b0, wa);
    $display("test outputs done");
    {ca.auto_enable, ca.ie_cts, ca.ie_dcd} = 3'h7;
    cts_a = 1'b0;
    tick(5);
    chk("tx enable", 1'b1, sa.tx_enable);
    dcd_a = 1'b0;
    tick(5);
    chk("rx enable", 1'b1, sa.rx_enable);
    cts_a = 1'b1;
    tick(5);
    chk("tx off", 1'b0, sa.tx_enable);
    chk("events", 1'b1, ev == 3);
    done = 1'b1;
    repeat (3) begin
      @(posedge rxc);
      #1;
      done = 1'b0;
    end
    tick(5);
    chk("hunt bit", 1'b1, sa.sync_hunt);
    tick(12);
    chk("hunt clear", 1'b0, sa.sync_hunt);
    chk("no event", 1'b1, ev == 3);
    ca.link.rate = RATE_X16;
    tick(40);
    repeat (64) begin
      @(posedge rxc);
      #1;
      if (bta === 1'b1) nt++;
    end
    chk("bit ticks", 1'b1, nt == 4);
    $display("test inputs done");
    chk("async sync pin", 1'b0, sybo);
    ca.link.mode = MODE_EXT_SYNC;
    tick(40);
    done = 1'b1;
    wait_rx("asm start", 1'b0);
    chk("first bit", exp_fb, afa);
    for (int m = 0; m < 2; m++) begin
      cb.link.mode = md[m];
      tick(40);
      hunt = (m == 0);
      flag = (m == 1);
      wait_rx("sync out", 1'b1);
      @(posedge rxc);
      #1;
      chk("sync unlatched", 1'b1, syb);
    end
    $display("test sync done");
    wrap_up();
  end
endmodule
